// File: hdl/srbs_sequencer.sv
/*
 * machine-cycle sequencer: walks each instruction group through its
 * bus cycles and drives address, data direction and bus strobes.
 * assumes start pulses only while idle, synchronous active-high reset.
 */
// What this block does
// RL1 - first fetch: read, memory, fetch low
// RL2 - second fetch same, status high
// RL3 - idle states: strobes high, data floats
// RL4 - block out zero: fetch, fetch, read, write
// RL5 - io write uses counter pair address
// RL6 - pair pop reads stack, stack plus one
// RL7 - index pop: two fetches then reads
// RL8 - pair push: two idles, writes below stack
// RL9 - index push: two fetches, two idles, writes
// RL10 - exit reads stack then stack plus one
// RL11 - false conditional exit: two idles only
// RL12 - true conditional exit: idle then reads
// RL13 - interrupt return: sleep low on first read
// RL14 - ten-cycle return with two refetches
// RL15 - compat bit picks where fetch goes low
// RL16 - accumulator rotate: single fetch only
// RL17 - prefixed rotate: two fetches, one idle
// RL18 - block out nonzero: two trailing idles
// RL19 - one clock per state, three-state access
`timescale 1ns/1ps
module srbs_sequencer
    import srbs_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        START,
    input  wire logic [3:0]  GROUP,
    input  wire logic        COND_TRUE,
    input  wire logic        COUNT_ZERO,
    input  wire logic        IO_COMPAT_BIT,
    input  wire logic [15:0] PC,
    input  wire logic [15:0] STACK_POINTER,
    input  wire logic [15:0] MEMORY_POINTER_PAIR,
    input  wire logic [15:0] COUNTER_PAIR,
    input  wire logic [7:0]  DATA_OUT,
    output logic      [15:0] ADDR,
    output logic      [7:0]  DATA_O,
    output logic             DATA_OE,
    output logic             READ_N,
    output logic             STORE_N,
    output logic             MEMORY_REQUEST_N,
    output logic             IO_REQUEST_N,
    output logic             OPCODE_FETCH_CYCLE_N,
    output logic             SLEEP_N,
    output logic             STATUS_INDICATOR,
    output logic             BUSY,
    output logic             DONE
);
    // ------------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001, // waiting for start
        S_LOOK = 4'b0010, // table read for current step
        S_BUS  = 4'b0100, // three-state bus access
        S_TI   = 4'b1000  // one internal idle state
    } srbs_state_t;

    srbs_state_t state_ff, nxt_state;
    logic [3:0]  group_ff;   // latched group
    logic        cond_ff;    // latched condition
    logic        zero_ff;    // latched count zero
    logic        compat_ff;  // latched compat bit
    logic [3:0]  step_ff;    // machine cycle index
    logic [1:0]  tst_ff;     // T-state within access
    logic [2:0]  kind_ff;    // table output
    logic [3:0]  len_ff;     // table length
    logic        done_ff;    // end-of-sequence pulse
    logic [3:0]  nxt_step;   // step the table reads ahead

    // ------------------------------------------------------------------
    // sequence table and address select
    // ------------------------------------------------------------------
    srbs_seq_rom u_rom (
        .CLK     (CLK),
        .RST     (RST),
        .group_i (BUSY ? group_ff : GROUP),
        .cond_i  (BUSY ? cond_ff : COND_TRUE),
        .zero_i  (BUSY ? zero_ff : COUNT_ZERO),
        .step_i  (nxt_step),
        .kind_ff (kind_ff),
        .len_ff  (len_ff)
    );

    wire        in_bus   = (state_ff == S_BUS);
    wire        in_ti    = (state_ff == S_TI);
    wire        is_idle  = (kind_ff == MC_IDLE);
    wire        last_mc  = (step_ff == 4'(len_ff - 4'h1));
    wire        bus_end  = in_bus && (tst_ff == T_BUS_LAST); // see RL19
    wire        mc_end   = bus_end || in_ti;
    assign nxt_step = (state_ff == S_IDLE) ? 4'h0 :
                      mc_end ? 4'(step_ff + 4'h1) : step_ff;
    wire [15:0] addr_w;
    wire [2:0]  src_w;

    // address source by kind and step position
    function automatic logic [2:0] pick_src(input logic [2:0] k,
                                            input logic [3:0] g,
                                            input logic       sec);
        if (k == MC_FETCH1 || k == MC_FETCH2 || k == MC_REFET)
            pick_src = SRC_PC;
        else if (k == MC_IOWR)
            pick_src = SRC_CNTR; // see RL5
        else if (k == MC_MWR)
            pick_src = sec ? SRC_SP_M2 : SRC_SP_M1; // see RL8
        else if (k == MC_MRD && g == OP_BLKOUT)
            pick_src = SRC_MEMPTR; // see RL4
        else if (k == MC_MRD || k == MC_RDSLP)
            pick_src = sec ? SRC_SP_P1 : SRC_SP; // see RL6
        else
            pick_src = SRC_NONE;
    endfunction : pick_src

    // second stack byte is the last cycle of every stack sequence
    wire second_b = last_mc;
    assign src_w  = pick_src(kind_ff, group_ff, second_b);

    srbs_addr_sel u_addr (
        .src_i    (src_w),
        .pc_i     (PC),
        .sp_i     (STACK_POINTER),
        .memptr_i (MEMORY_POINTER_PAIR),
        .cntr_i   (COUNTER_PAIR),
        .addr_o   (addr_w)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            S_IDLE: if (START) nxt_state = S_LOOK;
            S_LOOK: nxt_state = is_idle ? S_TI : S_BUS; // see RL3
            S_BUS:  if (bus_end)
                        nxt_state = last_mc ? S_IDLE : S_LOOK;
            S_TI:   nxt_state = last_mc ? S_IDLE : S_LOOK;
            default: nxt_state = S_IDLE;
        endcase
    end

    // state and counters
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= S_IDLE;
            step_ff  <= 4'h0;
            tst_ff   <= 2'h0;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            done_ff  <= mc_end && last_mc;
            tst_ff   <= in_bus ? 2'(tst_ff + 2'h1) : 2'h0;
            step_ff  <= nxt_step;
        end
    end

    // latch instruction inputs at start
    always_ff @(posedge CLK) begin
        if (RST) begin
            group_ff  <= OP_ROTA;
            cond_ff   <= 1'b0;
            zero_ff   <= 1'b1;
            compat_ff <= 1'b0;
        end else if (state_ff == S_IDLE && START) begin
            group_ff  <= GROUP;
            cond_ff   <= COND_TRUE;
            zero_ff   <= COUNT_ZERO;
            compat_ff <= IO_COMPAT_BIT;
        end
    end

    // ------------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------------
    wire fetch_k  = (kind_ff == MC_FETCH1) || (kind_ff == MC_FETCH2);
    wire reti10   = (group_ff == OP_RETI10);
    wire read_k   = fetch_k || (kind_ff == MC_REFET) ||
                    (kind_ff == MC_MRD) || (kind_ff == MC_RDSLP);
    wire write_k  = (kind_ff == MC_MWR) || (kind_ff == MC_IOWR);
    // fetch low per compat bit in ten-cycle return
    wire m1_low   = reti10 ? (fetch_k ? compat_ff :
                              (kind_ff == MC_REFET))
                           : fetch_k; // see RL15
    wire status_h = !(kind_ff == MC_FETCH1) ||
                    (reti10 && step_ff != 4'h0); // see RL2

    // registered bus outputs: held for the whole access
    always_ff @(posedge CLK) begin
        if (RST) begin
            ADDR                 <= 16'hFFFF;
            DATA_O               <= 8'h00;
            DATA_OE              <= 1'b0;
            READ_N               <= 1'b1;
            STORE_N              <= 1'b1;
            MEMORY_REQUEST_N     <= 1'b1;
            IO_REQUEST_N         <= 1'b1;
            OPCODE_FETCH_CYCLE_N <= 1'b1;
            SLEEP_N              <= 1'b1;
            STATUS_INDICATOR     <= 1'b1;
        end else if (nxt_state == S_BUS && state_ff == S_LOOK) begin
            ADDR                 <= addr_w;
            DATA_O               <= DATA_OUT;
            DATA_OE              <= write_k;
            READ_N               <= !read_k; // see RL1
            STORE_N              <= !write_k;
            MEMORY_REQUEST_N     <= (kind_ff == MC_IOWR);
            IO_REQUEST_N         <= (kind_ff != MC_IOWR); // see RL5
            OPCODE_FETCH_CYCLE_N <= !m1_low;
            SLEEP_N              <= (kind_ff != MC_RDSLP); // see RL13
            STATUS_INDICATOR     <= status_h;
        end else if (!(in_bus && !bus_end)) begin
            ADDR                 <= 16'hFFFF; // undefined, see RL3
            DATA_OE              <= 1'b0;
            READ_N               <= 1'b1;
            STORE_N              <= 1'b1;
            MEMORY_REQUEST_N     <= 1'b1;
            IO_REQUEST_N         <= 1'b1;
            OPCODE_FETCH_CYCLE_N <= 1'b1;
            SLEEP_N              <= 1'b1;
            STATUS_INDICATOR     <= 1'b1;
        end
    end

    assign BUSY = (state_ff != S_IDLE);
    assign DONE = done_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_IDLE_QUIET: assert property (@(posedge CLK) disable iff (RST) // see RL3
        in_ti |=> (READ_N && STORE_N && MEMORY_REQUEST_N && !DATA_OE))
        else $error("strobe active in idle state");
    AST_IOWR_STROBES: assert property (@(posedge CLK) disable iff (RST) // see RL5
        !IO_REQUEST_N |-> (!STORE_N && READ_N && MEMORY_REQUEST_N))
        else $error("io write strobes wrong");
    AST_BUS_THREE: assert property (@(posedge CLK) disable iff (RST) // see RL19
        $fell(READ_N) |-> !READ_N [*3] ##1 READ_N)
        else $error("read access not three states");
    AST_WRITE_MEM: assert property (@(posedge CLK) disable iff (RST) // see RL8
        ($fell(STORE_N) && IO_REQUEST_N) |-> !MEMORY_REQUEST_N)
        else $error("memory write without request");
    AST_FETCH_READ: assert property (@(posedge CLK) disable iff (RST) // see RL1
        !OPCODE_FETCH_CYCLE_N |-> (!READ_N && !MEMORY_REQUEST_N))
        else $error("fetch without read");
    AST_SLEEP_READ: assert property (@(posedge CLK) disable iff (RST) // see RL13
        !SLEEP_N |-> (!READ_N && OPCODE_FETCH_CYCLE_N))
        else $error("sleep low outside stack read");
    AST_ROTA_ONE: assert property (@(posedge CLK) disable iff (RST) // see RL16
        (state_ff == S_IDLE && START && GROUP == OP_ROTA) |-> ##5 DONE)
        else $error("accumulator rotate not one cycle");
    AST_FIRST_STATUS: assert property (@(posedge CLK) disable iff (RST) // see RL2
        !STATUS_INDICATOR |-> !READ_N && (!OPCODE_FETCH_CYCLE_N ||
            (reti10 && !compat_ff)))
        else $error("status low outside first fetch");
endmodule : srbs_sequencer

// File: hdl/srbs_pkg.sv
/*
 * shared constants for the stack/return bus sequencer.
 * assumes one clock, synchronous active-high reset.
 */
package srbs_pkg;
    // ------------------------------------------------------------------
    // address source selection
    // ------------------------------------------------------------------
    localparam logic [2:0] SRC_PC     = 3'h0; // opcode fetch address
    localparam logic [2:0] SRC_MEMPTR = 3'h1; // memory pointer pair
    localparam logic [2:0] SRC_CNTR   = 3'h2; // counter pair (io write)
    localparam logic [2:0] SRC_SP     = 3'h3; // stack pointer
    localparam logic [2:0] SRC_SP_P1  = 3'h4; // stack pointer plus one
    localparam logic [2:0] SRC_SP_M1  = 3'h5; // stack pointer minus one
    localparam logic [2:0] SRC_SP_M2  = 3'h6; // stack pointer minus two
    localparam logic [2:0] SRC_NONE   = 3'h7; // idle, undefined address

    // ------------------------------------------------------------------
    // machine cycle kinds
    // ------------------------------------------------------------------
    localparam logic [2:0] MC_FETCH1 = 3'h0; // first opcode byte
    localparam logic [2:0] MC_FETCH2 = 3'h1; // later opcode byte
    localparam logic [2:0] MC_MRD    = 3'h2; // memory read
    localparam logic [2:0] MC_MWR    = 3'h3; // memory write
    localparam logic [2:0] MC_IOWR   = 3'h4; // io write
    localparam logic [2:0] MC_IDLE   = 3'h5; // internal idle state
    localparam logic [2:0] MC_RDSLP  = 3'h6; // memory read, sleep low
    localparam logic [2:0] MC_REFET  = 3'h7; // refetch, status high

    // ------------------------------------------------------------------
    // instruction groups
    // ------------------------------------------------------------------
    localparam logic [3:0] OP_BLKOUT  = 4'h0; // block output repeat
    localparam logic [3:0] OP_POP     = 4'h1;
    localparam logic [3:0] OP_POPIDX  = 4'h2;
    localparam logic [3:0] OP_PUSH    = 4'h3;
    localparam logic [3:0] OP_PUSHIDX = 4'h4;
    localparam logic [3:0] OP_RET     = 4'h5;
    localparam logic [3:0] OP_RETC    = 4'h6; // conditional exit
    localparam logic [3:0] OP_INTERRUPT_RETURN    = 4'h7; // default return variant
    localparam logic [3:0] OP_RETI10  = 4'h8; // ten-cycle variant
    localparam logic [3:0] OP_ROTA    = 4'h9; // accumulator rotate
    localparam logic [3:0] OP_ROTR    = 4'hA; // prefixed reg rotate

    // ------------------------------------------------------------------
    // sizing and timing
    // ------------------------------------------------------------------
    localparam int          MAX_MC     = 10; // longest sequence
    localparam logic [3:0]  MC_LAST    = 4'h9;
    localparam logic [1:0]  T_BUS_LAST = 2'h2; // three states per access
    localparam int          T_STATE_NS = 25;   // one clock per T-state
    localparam int          CLK_NS     = 25;
    localparam int          T_CYCLES   = (T_STATE_NS + CLK_NS - 1) / CLK_NS;
endpackage : srbs_pkg

// File: hdl/srbs_seq_rom.sv
/*
 * sequence table: machine cycle kind for each step of an instruction
 * group, plus sequence length. registered output.
 * assumes the caller holds group and step stable for the read.
 */
`timescale 1ns/1ps
module srbs_seq_rom
    import srbs_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [3:0] group_i,
    input  wire logic       cond_i,
    input  wire logic       zero_i,
    input  wire logic [3:0] step_i,
    output logic      [2:0] kind_ff,
    output logic      [3:0] len_ff
);
    // ------------------------------------------------------------------
    // table lookup
    // ------------------------------------------------------------------
    logic [2:0] nxt_kind; // kind at requested step
    logic [3:0] nxt_len;  // cycles in whole sequence

    // decode group into cycle list
    always_comb begin
        nxt_kind = MC_IDLE;
        nxt_len  = 4'h1;
        unique case (group_i)
            OP_BLKOUT: begin // see RL4
                nxt_len = zero_i ? 4'h4 : 4'h6; // see RL18
                case (step_i)
                    4'h0: nxt_kind = MC_FETCH1;
                    4'h1: nxt_kind = MC_FETCH2;
                    4'h2: nxt_kind = MC_MRD;
                    4'h3: nxt_kind = MC_IOWR; // see RL5
                    default: nxt_kind = MC_IDLE;
                endcase
            end
            OP_POP: begin // see RL6
                nxt_len  = 4'h3;
                nxt_kind = (step_i == 4'h0) ? MC_FETCH1 : MC_MRD;
            end
            OP_POPIDX: begin // see RL7
                nxt_len  = 4'h4;
                nxt_kind = (step_i == 4'h0) ? MC_FETCH1 :
                           (step_i == 4'h1) ? MC_FETCH2 : MC_MRD;
            end
            OP_PUSH: begin // see RL8
                nxt_len  = 4'h5;
                nxt_kind = (step_i == 4'h0) ? MC_FETCH1 :
                           (step_i < 4'h3)  ? MC_IDLE : MC_MWR;
            end
            OP_PUSHIDX: begin // see RL9
                nxt_len  = 4'h6;
                nxt_kind = (step_i == 4'h0) ? MC_FETCH1 :
                           (step_i == 4'h1) ? MC_FETCH2 :
                           (step_i < 4'h4)  ? MC_IDLE : MC_MWR;
            end
            OP_RET: begin // see RL10
                nxt_len  = 4'h3;
                nxt_kind = (step_i == 4'h0) ? MC_FETCH1 : MC_MRD;
            end
            OP_RETC: begin
                if (!cond_i) begin // see RL11
                    nxt_len  = 4'h3;
                    nxt_kind = (step_i == 4'h0) ? MC_FETCH1 : MC_IDLE;
                end else begin // see RL12
                    nxt_len  = 4'h4;
                    nxt_kind = (step_i == 4'h0) ? MC_FETCH1 :
                               (step_i == 4'h1) ? MC_IDLE : MC_MRD;
                end
            end
            OP_INTERRUPT_RETURN: begin // see RL13
                nxt_len  = 4'h4;
                nxt_kind = (step_i == 4'h0) ? MC_FETCH1 :
                           (step_i == 4'h1) ? MC_FETCH2 :
                           (step_i == 4'h2) ? MC_RDSLP : MC_MRD;
            end
            OP_RETI10: begin // see RL14
                nxt_len = 4'hA;
                case (step_i)
                    4'h0: nxt_kind = MC_FETCH1;
                    4'h1: nxt_kind = MC_FETCH2;
                    4'h5: nxt_kind = MC_REFET;
                    4'h7: nxt_kind = MC_REFET;
                    4'h8: nxt_kind = MC_MRD;
                    4'h9: nxt_kind = MC_MRD;
                    default: nxt_kind = MC_IDLE;
                endcase
            end
            OP_ROTA: begin // see RL16
                nxt_len  = 4'h1;
                nxt_kind = MC_FETCH1;
            end
            OP_ROTR: begin // see RL17
                nxt_len  = 4'h3;
                nxt_kind = (step_i == 4'h0) ? MC_FETCH1 :
                           (step_i == 4'h1) ? MC_FETCH2 : MC_IDLE;
            end
            default: begin // unused group codes act as one fetch
                nxt_len  = 4'h1;
                nxt_kind = MC_FETCH1;
            end
        endcase
    end

    // register the table output
    always_ff @(posedge CLK) begin
        if (RST) begin
            kind_ff <= MC_IDLE;
            len_ff  <= 4'h1;
        end else begin
            kind_ff <= nxt_kind;
            len_ff  <= nxt_len;
        end
    end
endmodule : srbs_seq_rom

// File: hdl/srbs_addr_sel.sv
/*
 * address source selection and stack offsets for one bus cycle.
 * assumes stack pointer and pairs are stable during the instruction.
 */
`timescale 1ns/1ps
module srbs_addr_sel
    import srbs_pkg::*;
(
    input  wire logic [2:0]  src_i,
    input  wire logic [15:0] pc_i,
    input  wire logic [15:0] sp_i,
    input  wire logic [15:0] memptr_i,
    input  wire logic [15:0] cntr_i,
    output logic      [15:0] addr_o
);
    // ------------------------------------------------------------------
    // offsets around the stack pointer
    // ------------------------------------------------------------------
    wire [15:0] sp_p1 = 16'(sp_i + 16'h0001); // pop second byte
    wire [15:0] sp_m1 = 16'(sp_i - 16'h0001); // push high byte
    wire [15:0] sp_m2 = 16'(sp_i - 16'h0002); // push low byte

    assign addr_o = (src_i == SRC_PC)     ? pc_i     :
                    (src_i == SRC_MEMPTR) ? memptr_i :
                    (src_i == SRC_CNTR)   ? cntr_i   :
                    (src_i == SRC_SP)     ? sp_i     :
                    (src_i == SRC_SP_P1)  ? sp_p1    :
                    (src_i == SRC_SP_M1)  ? sp_m1    :
                    (src_i == SRC_SP_M2)  ? sp_m2    : 16'hFFFF;
endmodule : srbs_addr_sel

// File: verification/srbs_bus_model.sv
/*
 * bus partner: memory and io devices behind the sequencer's bus.
 * assumes registered strobes, one clock, no wait states requested.
 */
`timescale 1ns/1ps
module srbs_bus_model (
    input  wire logic        CLK,
    input  wire logic [15:0] ADDR,
    input  wire logic [7:0]  DATA_O,
    input  wire logic        DATA_OE,
    input  wire logic        STORE_N,
    input  wire logic        IO_REQUEST_N,
    output logic      [15:0] last_addr,
    output logic      [7:0]  last_data,
    output logic             last_io
);
    logic prev_wr_ff; // store strobe seen on the last clock
    initial begin
        prev_wr_ff = 1'b0;
        last_addr  = 16'h0000;
        last_data  = 8'h00;
        last_io    = 1'b0;
    end
    // latch each write on the first clock of its store strobe
    always @(posedge CLK) begin
        prev_wr_ff <= !STORE_N;
        if (!STORE_N && !prev_wr_ff) begin
            last_addr <= ADDR;
            // an undriven data bus reads back as a changing pattern
            last_data <= DATA_OE ? DATA_O : ~last_data;
            last_io   <= !IO_REQUEST_N;
        end
    end
endmodule : srbs_bus_model

// File: verification/tb_top.sv
/*
 * self-checking bench for the sequencer: plans each bus access in a
 * queue, a monitor compares accesses as they appear.
 * assumes the sequencer contract: start while idle, one clock per state.
 */
`timescale 1ns/1ps
module tb_top
    import srbs_pkg::*;
;
    // ------------------------------------------------------------------
    // signals and expected strobe patterns {rd,wr,memory_request_n,io,fetch,slp,st}
    // ------------------------------------------------------------------
    localparam logic [6:0] F1 = 7'h2A, F2 = 7'h2B, F1H = 7'h2E;
    localparam logic [6:0] MRD = 7'h2F, MWR = 7'h4F, IOW = 7'h57;
    localparam logic [6:0] RSL = 7'h2D;
    logic        CLK, RST, START, COND_TRUE, COUNT_ZERO, IO_COMPAT_BIT;
    logic [3:0]  GROUP;
    logic [15:0] PC, STACK_POINTER, MEMORY_POINTER_PAIR, COUNTER_PAIR, ADDR;
    logic [7:0]  DATA_OUT, DATA_O, m_data;
    logic        DATA_OE, READ_N, STORE_N, MEMORY_REQUEST_N, IO_REQUEST_N;
    logic        OPCODE_FETCH_CYCLE_N, SLEEP_N, STATUS_INDICATOR, BUSY;
    logic        DONE, m_io, a, prev_act;
    logic [15:0] m_addr;
    logic [23:0] x, exp_q[$];      // {address checked, strobes, address}
    logic [6:0]  sig;              // sampled strobe vector
    int          bad_count, checked, cyc, nb, ni, run_len;
    integer      seed = 32'hc35c;
    srbs_sequencer dut (.CLK(CLK), .RST(RST), .START(START), .GROUP(GROUP),
        .COND_TRUE(COND_TRUE), .COUNT_ZERO(COUNT_ZERO),
        .IO_COMPAT_BIT(IO_COMPAT_BIT), .PC(PC), .STACK_POINTER(STACK_POINTER),
        .MEMORY_POINTER_PAIR(MEMORY_POINTER_PAIR), .COUNTER_PAIR(COUNTER_PAIR),
        .DATA_OUT(DATA_OUT), .ADDR(ADDR), .DATA_O(DATA_O), .DATA_OE(DATA_OE),
        .READ_N(READ_N), .STORE_N(STORE_N),
        .MEMORY_REQUEST_N(MEMORY_REQUEST_N), .IO_REQUEST_N(IO_REQUEST_N),
        .OPCODE_FETCH_CYCLE_N(OPCODE_FETCH_CYCLE_N), .SLEEP_N(SLEEP_N),
        .STATUS_INDICATOR(STATUS_INDICATOR), .BUSY(BUSY), .DONE(DONE));
    srbs_bus_model partner (.CLK(CLK), .ADDR(ADDR), .DATA_O(DATA_O),
        .DATA_OE(DATA_OE), .STORE_N(STORE_N), .IO_REQUEST_N(IO_REQUEST_N),
        .last_addr(m_addr), .last_data(m_data), .last_io(m_io));
    // 25 ns clock
    always #12.5 CLK = ~CLK;
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task check(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    task wrap_up;
        $display("mismatches %0d comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    // note one planned bus access
    task plan(input logic [6:0] s, input logic [15:0] ad, input logic k);
        exp_q.push_back({k, s, ad});
        nb++;
    endtask : plan
    task pop2;
        plan(MRD, STACK_POINTER, 1'b1);
        plan(MRD, STACK_POINTER + 16'h0001, 1'b1);
    endtask : pop2
    task push2;
        plan(MWR, STACK_POINTER - 16'h0001, 1'b1);
        plan(MWR, STACK_POINTER - 16'h0002, 1'b1);
    endtask : push2
    // one instruction: drive, plan, wait for done, check length and writes
    task run(input logic [3:0] g, input logic c, z, k, input bit spur);
        int t0, n;
        nb = 0;
        ni = 0;
        n  = 0;
        @(posedge CLK);
        GROUP <= g; COND_TRUE <= c; COUNT_ZERO <= z; IO_COMPAT_BIT <= k;
        START <= 1'b1; PC <= 16'($random(seed));
        STACK_POINTER <= 16'($random(seed));
        MEMORY_POINTER_PAIR <= 16'($random(seed));
        COUNTER_PAIR <= 16'($random(seed)); DATA_OUT <= 8'($random(seed));
        @(posedge CLK);
        t0 = cyc;
        START <= spur;  // a start while busy must be ignored
        GROUP <= spur ? OP_POP : g;
        plan(g == OP_RETI10 && !k ? F1H : F1, PC, 1'b1);
        case (g)
            OP_BLKOUT: begin
                plan(F2, PC, 1'b0); plan(MRD, MEMORY_POINTER_PAIR, 1'b1);
                plan(IOW, COUNTER_PAIR, 1'b1); ni = z ? 0 : 2;
            end
            OP_POP, OP_RET: pop2();
            OP_POPIDX: begin plan(F2, PC, 1'b0); pop2(); end
            OP_PUSH: begin ni = 2; push2(); end
            OP_PUSHIDX: begin plan(F2, PC, 1'b0); ni = 2; push2(); end
            OP_RETC: if (c) begin ni = 1; pop2(); end else ni = 2;
            OP_INTERRUPT_RETURN: begin
                plan(F2, PC, 1'b0); plan(RSL, STACK_POINTER, 1'b1);
                plan(MRD, STACK_POINTER + 16'h0001, 1'b1);
            end
            OP_RETI10: begin
                plan(k ? F2 : MRD, PC, 1'b0); plan(F2, PC, 1'b0);
                plan(F2, PC, 1'b0); ni = 4; pop2();
            end
            OP_ROTA: ;
            default: begin plan(F2, PC, 1'b0); ni = 1; end
        endcase
        @(posedge CLK);
        START <= 1'b0;
        GROUP <= g;
        do begin @(posedge CLK); n++; end while (DONE !== 1'b1 && n < 200);
        check(cyc - t0 == 4 * nb + 2 * ni + 1 && BUSY === 1'b0,
              "sequence length");
        check(exp_q.size() == 0, "accesses missing");
        if (g == OP_PUSH || g == OP_PUSHIDX)
            check(m_addr === STACK_POINTER - 16'h0002 && m_data === DATA_OUT
                  && m_io === 1'b0, "last stack write");
        if (g == OP_BLKOUT)
            check(m_addr === COUNTER_PAIR && m_data === DATA_OUT
                  && m_io === 1'b1, "io write");
    endtask : run
    // ------------------------------------------------------------------
    // monitor: compares each access start, watches idle levels, timeout
    // ------------------------------------------------------------------
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            wrap_up();
        end
        sig = {READ_N, STORE_N, MEMORY_REQUEST_N, IO_REQUEST_N,
               OPCODE_FETCH_CYCLE_N, SLEEP_N, STATUS_INDICATOR};
        a = (READ_N === 1'b0) || (STORE_N === 1'b0);
        if (!RST && a && !prev_act) begin
            x = exp_q.size() > 0 ? exp_q.pop_front() : 24'h000000;
            check(sig === x[22:16], "strobe pattern");
            if (x[23]) check(ADDR === x[15:0], "address");
        end
        if (!RST && !a && prev_act) check(run_len == 3, "access length");
        if (!RST && !a) check(sig === 7'h7F && DATA_OE === 1'b0, "idle");
        if (!RST && STORE_N === 1'b0)
            check(DATA_OE === 1'b1 && DATA_O === DATA_OUT, "write data");
        run_len  = a ? run_len + 1 : 0;
        prev_act = a;
    end
    // main sequence: every group and variant, back to back
    initial begin
        CLK = 1'b0; RST = 1'b1; START = 1'b0; GROUP = 4'h0; COND_TRUE = 1'b0;
        COUNT_ZERO = 1'b0; IO_COMPAT_BIT = 1'b0; PC = 16'h0000;
        STACK_POINTER = 16'h0000; MEMORY_POINTER_PAIR = 16'h0000;
        COUNTER_PAIR = 16'h0000; DATA_OUT = 8'h00; prev_act = 1'b0;
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        run(OP_BLKOUT, 1'b0, 1'b1, 1'b0, 1'b0);
        run(OP_BLKOUT, 1'b0, 1'b0, 1'b0, 1'b0);
        run(OP_POP, 1'b0, 1'b0, 1'b0, 1'b0);
        run(OP_POPIDX, 1'b0, 1'b0, 1'b0, 1'b0);
        run(OP_PUSH, 1'b0, 1'b0, 1'b0, 1'b0);
        run(OP_PUSHIDX, 1'b0, 1'b0, 1'b0, 1'b0);
        run(OP_RET, 1'b0, 1'b0, 1'b0, 1'b0);
        run(OP_RETC, 1'b0, 1'b0, 1'b0, 1'b0);
        run(OP_RETC, 1'b1, 1'b0, 1'b0, 1'b0);
        run(OP_INTERRUPT_RETURN, 1'b0, 1'b0, 1'b0, 1'b0);
        run(OP_RETI10, 1'b0, 1'b0, 1'b1, 1'b0);
        run(OP_RETI10, 1'b0, 1'b0, 1'b0, 1'b0);
        run(OP_ROTA, 1'b0, 1'b0, 1'b0, 1'b0);
        run(OP_ROTR, 1'b0, 1'b0, 1'b0, 1'b1);
        wrap_up();
    end
endmodule : tb_top
